/* inc/pcr_pkg.sv */
// Constants for the regulator configuration register bank.
// Assumes a 250 MHz system clock and a command-level PMBus engine upstream.
`default_nettype none
package pcr_pkg;
  // ----------------------------------------
  // Command codes of the four registers
  // ----------------------------------------
  localparam logic [7:0] CMD_MISC = 8'hD1;
  localparam logic [7:0] CMD_GRP = 8'hD3;
  localparam logic [7:0] CMD_PGD = 8'hD4;
  localparam logic [7:0] CMD_GAIN = 8'hD5;
  // ----------------------------------------
  // Reset values and writable bit masks
  // ----------------------------------------
  localparam logic [15:0] MISC_RST = 16'h0000;
  localparam logic [15:0] GRP_RST = 16'h0000;
  localparam logic [15:0] PGD_RST = 16'h0000;
  localparam logic [7:0] GAIN_RST = 8'h01;
  localparam logic [15:0] MISC_MASK = 16'hFC87;
  localparam logic [15:0] GRP_MASK = 16'hFF0F;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int MD_HI = 15;
  localparam int MD_LO = 11;
  localparam int DRV_BIT = 10;
  localparam int MD_EN_BIT = 7;
  localparam int GOOD_PP_BIT = 2;
  localparam int XT_EN_BIT = 1;
  localparam int XT_FLT_BIT = 0;
  localparam int POS_HI = 14;
  localparam int POS_LO = 13;
  localparam int RID_HI = 12;
  localparam int RID_LO = 8;
  localparam int PH_HI = 3;
  localparam int PH_LO = 0;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned MS_PERIOD_PS = 1000000000;
  localparam int unsigned MS_CYCLES = MS_PERIOD_PS / CLK_PERIOD_PS;
  localparam logic [12:0] PGD_MAX_MS = 13'h1388;
  // Power-good sequencer states
  typedef enum logic [1:0] {
    PCR_OUT_BELOW = 2'b00,
    PCR_OUT_WAIT = 2'b01,
    PCR_OUT_GOOD = 2'b10
  } pcr_good_state_t;
endpackage : pcr_pkg
`default_nettype wire

/* hw/pcr_sync3.sv */
// Three-stage synchroniser with agreement filter for one level.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module pcr_sync3 (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Level in and out
  input wire logic async_in,
  output logic level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  // Stage one feeds only stage two, so metastability stays contained
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // A change counts once stages two and three agree
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      level_out <= 1'b0;
    end else if (s2_r == s3_r) begin
      level_out <= s3_r;
    end
  end
endmodule : pcr_sync3
`default_nettype wire

/* hw/pcr_lin_ms.sv */
// Converts a linear-format delay word to whole milliseconds.
// Assumes the word holds a 5-bit exponent over an 11-bit mantissa.
`timescale 1ns/1ps
`default_nettype none
module pcr_lin_ms (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Linear value in, rounded milliseconds out
  input wire logic [15:0] lin_in,
  output logic [12:0] ms_out
);
  logic [31:0] wide;
  logic [4:0] sh;
  logic [12:0] ms_nxt;
  // Round half up; negative values give zero, large ones saturate
  always_comb begin
    wide = 32'h0;
    sh = 5'h0;
    if (lin_in[10]) begin
      wide = 32'h0;
    end else if (!lin_in[15]) begin
      sh = lin_in[15:11];
      wide = {21'h0, lin_in[10:0]} << sh;
    end else begin
      sh = 5'(~lin_in[15:11] + 5'h1);
      wide = ({21'h0, lin_in[10:0]} + (32'h1 << (sh - 5'h1))) >> sh;
    end
    if (wide > {19'h0, pcr_pkg::PGD_MAX_MS}) begin
      ms_nxt = pcr_pkg::PGD_MAX_MS;
    end else begin
      ms_nxt = wide[12:0];
    end
  end
  // Registered so the delay comparator sees a clean value
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ms_out <= 13'h0;
    end else begin
      ms_out <= ms_nxt; // R12
    end
  end
endmodule : pcr_lin_ms
`default_nettype wire

/* hw/pcr_regs.sv */
// Configuration register bank of a point-of-load regulator controller.
// Assumes a PMBus engine that delivers decoded word and byte commands.
//
// Overview of operation
// R1: Minimum duty is five bits 15:11, 0-31, in units of two periods.
// R2: Minimum duty limit applies only while bit 7 is set.
// R3: Bit 10 enables power-stage drive; clear disables it.
// R4: Bit 2 clear gives open-drain good pin, set gives push-pull.
// R5: Bit 1 enables external sensor for read-current temperature compensation.
// R6: Bit 0 picks external sensor for temperature faults, else internal.
// R7: Five-bit rail identifier for sharing, sequencing and fault spreading.
// R8: Host writes same rail identifier into all devices of a group.
// R9: Phase position code 0-3 means positions one to four.
// R10: Phase count code is count minus one; 1,3,5,7 are valid.
// R11: Good pin asserts after the programmed delay, 0 to 5000 ms.
// R12: Programmed delay is rounded to the nearest whole millisecond.
// R13: Eight-bit ramp gain sets rise time on sharing rails.
// R14: Sharing ramp mode follows automatically from a sharing setup.
// R15: Sharing ramp disables high-bandwidth turn-on, runs low bandwidth.
// R16: Once output is good, high-bandwidth loop is restored.
// R17: Sharing setup forbids soft-off and ignores the fall time.
// R18: Delay counts one-millisecond ticks and restarts when output drops.
// R19: Host reaches misc register with word transfers at its code.
`timescale 1ns/1ps
`default_nettype none
module pcr_regs #(
  parameter int unsigned MS_CYCLES = pcr_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Decoded command port from the bus engine
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic cmd_word,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_ack,
  output logic cmd_nack,
  // Output monitor and fall-time setting
  input wire logic vout_above_pg_on,
  input wire logic [15:0] turnoff_fall_time,
  // Duty and drive
  output logic [5:0] min_duty_tsw,
  output logic min_duty_on,
  output logic power_drive_en,
  // Temperature sensing
  output logic ext_temp_sense_en,
  output logic temp_comp_ext,
  output logic temp_fault_ext,
  // Group bus and phase setup
  output logic [4:0] rail_group_id,
  output logic [2:0] phase_position,
  output logic [3:0] phase_count,
  output logic phase_count_ok,
  // Ramp and loop control
  output logic [7:0] ramp_gain,
  output logic sharing_mode,
  output logic hbw_turnon_ramp_en,
  output logic loop_high_bw,
  output logic soft_off_en,
  output logic [15:0] turnoff_fall_eff,
  // Power good
  output logic [12:0] good_delay_ms,
  output logic power_good,
  output logic output_good_pin_o,
  output logic output_good_pin_oe
);
  // ----------------------------------------
  // Register storage and command decode
  // ----------------------------------------
  logic [15:0] misc_r;
  logic [15:0] grp_r;
  logic [15:0] pgd_r;
  logic [7:0] gain_r;
  logic hit;
  logic type_ok;
  logic take;
  logic [15:0] rd_nxt;

  // Byte for the gain, word for the rest; a mismatch is refused
  always_comb begin
    hit = 1'b1;
    rd_nxt = 16'h0000;
    case (cmd_code)
      pcr_pkg::CMD_MISC: rd_nxt = misc_r;
      pcr_pkg::CMD_GRP: rd_nxt = grp_r;
      pcr_pkg::CMD_PGD: rd_nxt = pgd_r;
      pcr_pkg::CMD_GAIN: rd_nxt = {8'h00, gain_r};
      default: hit = 1'b0;
    endcase
    type_ok = (cmd_code == pcr_pkg::CMD_GAIN) ? !cmd_word : cmd_word; // R19
    take = hit && type_ok;
  end

  // Configuration registers; reserved bits are masked to zero
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      misc_r <= pcr_pkg::MISC_RST;
      grp_r <= pcr_pkg::GRP_RST;
      pgd_r <= pcr_pkg::PGD_RST;
      gain_r <= pcr_pkg::GAIN_RST;
    end else if (cmd_wr && take) begin
      case (cmd_code)
        pcr_pkg::CMD_MISC: misc_r <= cmd_wdata & pcr_pkg::MISC_MASK; // R19
        pcr_pkg::CMD_GRP: grp_r <= cmd_wdata & pcr_pkg::GRP_MASK; // R7
        pcr_pkg::CMD_PGD: pgd_r <= cmd_wdata;
        pcr_pkg::CMD_GAIN: gain_r <= cmd_wdata[7:0]; // R13
        default: misc_r <= misc_r;
      endcase
    end
  end

  // Answer one cycle after the request; read data held until next accepted read
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cmd_ack <= 1'b0;
      cmd_nack <= 1'b0;
      cmd_rdata <= 16'h0000;
    end else begin
      cmd_ack <= (cmd_wr || cmd_rd) && take;
      cmd_nack <= (cmd_wr || cmd_rd) && !take;
      if (cmd_rd && take) begin
        cmd_rdata <= rd_nxt;
      end
    end
  end

  // ----------------------------------------
  // Decoded configuration outputs
  // ----------------------------------------
  logic [3:0] ph_code;
  logic sharing_nxt;
  assign ph_code = grp_r[pcr_pkg::PH_HI:pcr_pkg::PH_LO];
  // Only odd codes up to seven describe a real multi-phase rail
  assign sharing_nxt = ph_code[0] && !ph_code[3]; // R14

  // Duty, drive and sensor selects, each from its register bit
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      min_duty_tsw <= 6'h00;
      min_duty_on <= 1'b0;
      power_drive_en <= 1'b0;
      ext_temp_sense_en <= 1'b0;
      temp_comp_ext <= 1'b0;
      temp_fault_ext <= 1'b0;
    end else begin
      min_duty_on <= misc_r[pcr_pkg::MD_EN_BIT]; // R2
      if (misc_r[pcr_pkg::MD_EN_BIT]) begin
        min_duty_tsw <= {misc_r[pcr_pkg::MD_HI:pcr_pkg::MD_LO], 1'b0}; // R1
      end else begin
        min_duty_tsw <= 6'h00; // R2
      end
      power_drive_en <= misc_r[pcr_pkg::DRV_BIT]; // R3
      ext_temp_sense_en <= misc_r[pcr_pkg::XT_EN_BIT]; // R5
      temp_comp_ext <= misc_r[pcr_pkg::XT_EN_BIT]; // R5
      temp_fault_ext <= misc_r[pcr_pkg::XT_FLT_BIT]; // R6
    end
  end

  // Group bus identity and phase decode
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rail_group_id <= 5'h00;
      phase_position <= 3'h1;
      phase_count <= 4'h1;
      phase_count_ok <= 1'b0;
      ramp_gain <= pcr_pkg::GAIN_RST;
    end else begin
      rail_group_id <= grp_r[pcr_pkg::RID_HI:pcr_pkg::RID_LO]; // R7
      phase_position <= {1'b0, grp_r[pcr_pkg::POS_HI:pcr_pkg::POS_LO]}
                        + 3'h1; // R9
      phase_count <= ph_code + 4'h1; // R10
      phase_count_ok <= sharing_nxt; // R10
      ramp_gain <= gain_r; // R13
    end
  end

  // ----------------------------------------
  // Power-good delay sequencer
  // ----------------------------------------
  logic vout_ok;
  logic [12:0] delay_ms;
  logic [17:0] pre_r;
  logic [12:0] ms_r;
  logic tick;
  pcr_pkg::pcr_good_state_t good_state_r;

  // Comparator output is asynchronous to the controller clock
  pcr_sync3 u_vout_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in(vout_above_pg_on),
    .level_out(vout_ok)
  );

  // Linear delay word rounded to whole milliseconds
  pcr_lin_ms u_delay_conv (
    .sys_clk(sys_clk),
    .reset(reset),
    .lin_in(pgd_r),
    .ms_out(delay_ms)
  );

  assign tick = (pre_r == 18'(MS_CYCLES - 1));

  // Millisecond prescaler and counter; cleared whenever output drops
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pre_r <= 18'h0;
      ms_r <= 13'h0;
    end else if (!vout_ok || good_state_r != pcr_pkg::PCR_OUT_WAIT) begin
      pre_r <= 18'h0; // R18
      ms_r <= 13'h0; // R18
    end else if (tick) begin
      pre_r <= 18'h0;
      if (ms_r != pcr_pkg::PGD_MAX_MS) begin
        ms_r <= ms_r + 13'h1; // R18
      end
    end else begin
      pre_r <= pre_r + 18'h1;
    end
  end

  // Good is held off until the rounded delay has elapsed
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      good_state_r <= pcr_pkg::PCR_OUT_BELOW;
    end else begin
      case (good_state_r)
        pcr_pkg::PCR_OUT_BELOW: begin
          if (vout_ok) begin
            good_state_r <= pcr_pkg::PCR_OUT_WAIT;
          end
        end
        pcr_pkg::PCR_OUT_WAIT: begin
          if (!vout_ok) begin
            good_state_r <= pcr_pkg::PCR_OUT_BELOW; // R18
          end else if (ms_r >= delay_ms) begin
            good_state_r <= pcr_pkg::PCR_OUT_GOOD; // R11
          end
        end
        pcr_pkg::PCR_OUT_GOOD: begin
          if (!vout_ok) begin
            good_state_r <= pcr_pkg::PCR_OUT_BELOW;
          end
        end
        default: good_state_r <= pcr_pkg::PCR_OUT_BELOW;
      endcase
    end
  end

  // ----------------------------------------
  // Pin drive and ramp mode outputs
  // ----------------------------------------
  logic good_now;
  assign good_now = (good_state_r == pcr_pkg::PCR_OUT_GOOD);

  // Open-drain only pulls low; push-pull drives both levels
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      power_good <= 1'b0;
      output_good_pin_o <= 1'b0;
      output_good_pin_oe <= 1'b1;
      good_delay_ms <= 13'h0;
    end else begin
      power_good <= good_now; // R11
      good_delay_ms <= delay_ms; // R12
      if (misc_r[pcr_pkg::GOOD_PP_BIT]) begin
        output_good_pin_o <= good_now; // R4
        output_good_pin_oe <= 1'b1; // R4
      end else begin
        output_good_pin_o <= 1'b0; // R4
        output_good_pin_oe <= !good_now; // R4
      end
    end
  end

  // Sharing rails ramp at low bandwidth until good, never soft-off
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sharing_mode <= 1'b0;
      hbw_turnon_ramp_en <= 1'b1;
      loop_high_bw <= 1'b1;
      soft_off_en <= 1'b1;
      turnoff_fall_eff <= 16'h0000;
    end else begin
      sharing_mode <= sharing_nxt; // R14
      hbw_turnon_ramp_en <= !sharing_nxt; // R15
      loop_high_bw <= !sharing_nxt || good_now; // R16
      soft_off_en <= !sharing_nxt; // R17
      turnoff_fall_eff <= sharing_nxt ? 16'h0000 : turnoff_fall_time; // R17
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_min_duty_val;
    @(posedge sys_clk) disable iff (reset)
    misc_r[pcr_pkg::MD_EN_BIT] |=>
      min_duty_tsw == {$past(misc_r[15:11]), 1'b0};
  endproperty
  a_min_duty_val: assert property (p_min_duty_val) // R1
    else $error("minimum duty not twice the field");

  property p_min_duty_off;
    @(posedge sys_clk) disable iff (reset)
    !misc_r[pcr_pkg::MD_EN_BIT] |=> !min_duty_on && min_duty_tsw == 6'h00;
  endproperty
  a_min_duty_off: assert property (p_min_duty_off) // R2
    else $error("minimum duty active while disabled");

  property p_drive;
    @(posedge sys_clk) disable iff (reset)
    (cmd_wr && take && cmd_code == pcr_pkg::CMD_MISC) |=>
      ##1 power_drive_en == $past(cmd_wdata[10], 2);
  endproperty
  a_drive: assert property (p_drive) // R3
    else $error("drive enable does not follow write");

  property p_od_pin;
    @(posedge sys_clk) disable iff (reset)
    (!misc_r[pcr_pkg::GOOD_PP_BIT] && !good_now) |=>
      output_good_pin_oe && !output_good_pin_o;
  endproperty
  a_od_pin: assert property (p_od_pin) // R4
    else $error("open-drain pin not pulling low");

  property p_pos;
    @(posedge sys_clk) disable iff (reset)
    1'b1 |=> phase_position == 3'($past(grp_r[14:13]) + 2'd0) + 3'h1;
  endproperty
  a_pos: assert property (p_pos) // R9
    else $error("phase position decode wrong");

  property p_good_delay;
    @(posedge sys_clk) disable iff (reset)
    $rose(power_good) |-> $past(ms_r, 2) >= $past(delay_ms, 2);
  endproperty
  a_good_delay: assert property (p_good_delay) // R11
    else $error("good asserted before delay");

  property p_restart;
    @(posedge sys_clk) disable iff (reset)
    !vout_ok |=> ms_r == 13'h0 ##1 !power_good;
  endproperty
  a_restart: assert property (p_restart) // R18
    else $error("delay count not restarted");

  property p_hbw_back;
    @(posedge sys_clk) disable iff (reset)
    good_now |=> loop_high_bw;
  endproperty
  a_hbw_back: assert property (p_hbw_back) // R16
    else $error("loop not restored after good");

  property p_soft_off;
    @(posedge sys_clk) disable iff (reset)
    sharing_nxt |=> !soft_off_en && turnoff_fall_eff == 16'h0000
      && !hbw_turnon_ramp_en;
  endproperty
  a_soft_off: assert property (p_soft_off) // R17
    else $error("soft-off allowed on sharing rail");
endmodule : pcr_regs
`default_nettype wire

/* tb/pcr_far_model.sv */
// Far-side model: output level monitor and the pulled-up good line.
// Assumes the bench chooses when the output is above threshold.
`timescale 1ns/1ps
`default_nettype none
module pcr_far_model (
  // Device pin
  input wire logic pin_o,
  input wire logic pin_oe,
  // Bench control and wire levels
  input wire logic vout_req,
  output wire logic vout_above_pg_on,
  output wire logic pin_level
);
  // Comparator edge lands off the clock, as the real monitor is async
  assign #1.3 vout_above_pg_on = vout_req;
  // Pull-up holds the line high whenever nobody drives it
  assign pin_level = pin_oe ? pin_o : 1'b1;
endmodule : pcr_far_model
`default_nettype wire

/* tb/pcr_regs_bench.sv */
// Self-checking bench for the configuration register bank.
// Assumes a shortened millisecond tick of ten clocks.
`timescale 1ns/1ps
`default_nettype none
module pcr_regs_bench;
  localparam int unsigned MSC = 10;
  logic sys_clk, reset, cmd_wr, cmd_rd, cmd_word, vout_req, sh;
  logic [7:0] cmd_code, ramp_gain;
  logic [15:0] cmd_wdata, turnoff_fall_time, cmd_rdata, turnoff_fall_eff, d;
  logic cmd_ack, cmd_nack, min_duty_on, power_drive_en, ext_temp_sense_en;
  logic temp_comp_ext, temp_fault_ext, phase_count_ok, sharing_mode;
  logic hbw_turnon_ramp_en, loop_high_bw, soft_off_en, power_good;
  logic output_good_pin_o, output_good_pin_oe, vout_above_pg_on, pin_level;
  logic [5:0] min_duty_tsw;
  logic [4:0] rail_group_id;
  logic [2:0] phase_position;
  logic [3:0] phase_count;
  logic [12:0] good_delay_ms;
  logic [15:0] w [6];
  int seed, errors, check_count, ms;

  pcr_regs #(.MS_CYCLES(MSC)) i_pcr_regs (.sys_clk, .reset, .cmd_code,
    .cmd_wr, .cmd_rd, .cmd_word, .cmd_wdata, .cmd_rdata, .cmd_ack,
    .cmd_nack, .vout_above_pg_on, .turnoff_fall_time, .min_duty_tsw,
    .min_duty_on, .power_drive_en, .ext_temp_sense_en, .temp_comp_ext,
    .temp_fault_ext, .rail_group_id, .phase_position, .phase_count,
    .phase_count_ok, .ramp_gain, .sharing_mode, .hbw_turnon_ramp_en,
    .loop_high_bw, .soft_off_en, .turnoff_fall_eff, .good_delay_ms,
    .power_good, .output_good_pin_o, .output_good_pin_oe);
  pcr_far_model i_pcr_far_model (.pin_o(output_good_pin_o),
    .pin_oe(output_good_pin_oe), .vout_req, .vout_above_pg_on, .pin_level);

  // Free-running 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Expectations and checks
  // ----------------------------------------
  // Linear word to whole ms, half rounds up, clamped to the legal range
  function automatic int lin_ms(input logic [15:0] x);
    int e, m, v;
    e = $signed(x[15:11]);
    m = $signed(x[10:0]);
    if (m < 0) v = 0;
    else if (e >= 0) v = m <<< e;
    else v = (m + (1 <<< (-e - 1))) >>> -e;
    return (v > 5000) ? 5000 : v;
  endfunction : lin_ms

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  // One transfer; an accepted read expects x back, a refusal expects nack only
  task automatic acc(input logic [7:0] c, input logic wr, input logic wd,
    input logic [15:0] x, input logic ok);
    @(posedge sys_clk);
    cmd_code <= c;
    cmd_wr <= wr;
    cmd_rd <= !wr;
    cmd_word <= wd;
    cmd_wdata <= x;
    @(posedge sys_clk);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    #1;
    chk({14'h0, cmd_ack, cmd_nack}, {14'h0, ok, !ok});
    if (!wr && ok) chk(cmd_rdata, x);
  endtask : acc

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  // Bounded wait for the good flag; running out ends the run
  task automatic wait_good(input logic v, input int n);
    int i;
    i = 0;
    while (power_good !== v && i < n) begin
      cyc(1);
      i++;
    end
    if (power_good !== v) begin
      errors++;
      finish_test();
    end
  endtask : wait_good

  // Level changes on the edge; callers look a little after it
  task automatic set_vout(input logic v);
    @(posedge sys_clk);
    vout_req <= v;
    #1;
  endtask : set_vout

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 62;
    errors = 0;
    check_count = 0;
    reset = 1'b1;
    {cmd_wr, cmd_rd, cmd_word, vout_req} = 4'h0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
    turnoff_fall_time = 16'h0000;
    w = '{16'h0003, 16'hF805, 16'hF804, 16'h1000, 16'h07FF, 16'h17D0};
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    // Reset contents of all four registers
    acc(pcr_pkg::CMD_MISC, 0, 1, pcr_pkg::MISC_RST, 1);
    acc(pcr_pkg::CMD_GRP, 0, 1, pcr_pkg::GRP_RST, 1);
    acc(pcr_pkg::CMD_PGD, 0, 1, pcr_pkg::PGD_RST, 1);
    acc(pcr_pkg::CMD_GAIN, 0, 0, {8'h00, pcr_pkg::GAIN_RST}, 1);
    chk({13'h0, phase_position}, 16'h0001);
    // Misc fields, all-ones first to hit the top of every field
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 16'hFFFF : 16'($random(seed));
      acc(pcr_pkg::CMD_MISC, 1, 1, d, 1);
      acc(pcr_pkg::CMD_MISC, 0, 1, d & pcr_pkg::MISC_MASK, 1);
      chk({10'h0, min_duty_tsw}, d[7] ? {10'h0, d[15:11], 1'b0} : 16'h0);
      chk({15'h0, min_duty_on}, {15'h0, d[7]});
      chk({15'h0, power_drive_en}, {15'h0, d[10]});
      chk({14'h0, ext_temp_sense_en, temp_comp_ext},
        {14'h0, d[1], d[1]});
      chk({15'h0, temp_fault_ext}, {15'h0, d[0]});
    end
    // Every phase-count code with random position and rail id
    for (int i = 0; i < 16; i++) begin
      d = 16'($random(seed));
      d[3:0] = i[3:0];
      @(posedge sys_clk);
      turnoff_fall_time <= 16'($random(seed));
      acc(pcr_pkg::CMD_GRP, 1, 1, d, 1);
      acc(pcr_pkg::CMD_GRP, 0, 1, d & pcr_pkg::GRP_MASK, 1);
      sh = d[0] & !d[3];
      chk({11'h0, rail_group_id}, {11'h0, d[12:8]});
      chk({8'h0, phase_count_ok, phase_position, phase_count},
        {8'h0, sh, {1'b0, d[14:13]} + 3'h1, d[3:0] + 4'h1});
      chk({12'h0, sharing_mode, hbw_turnon_ramp_en, soft_off_en, loop_high_bw},
        {12'h0, sh, !sh, !sh, !sh});
      chk(turnoff_fall_eff, sh ? 16'h0 : turnoff_fall_time);
    end
    // Byte gain, then wrong types and an unknown code are refused
    d = 16'($random(seed)) & 16'h00FF;
    acc(pcr_pkg::CMD_GAIN, 1, 0, d, 1);
    acc(pcr_pkg::CMD_GAIN, 1, 1, 16'h00FF, 0);
    acc(pcr_pkg::CMD_MISC, 1, 0, 16'hFFFF, 0);
    acc(8'hD2, 0, 1, 16'h0000, 0);
    acc(pcr_pkg::CMD_GAIN, 0, 0, d, 1);
    chk({8'h0, ramp_gain}, d);
    // Sharing setup so the loop bandwidth follows the good flag
    acc(pcr_pkg::CMD_GRP, 1, 1, 16'h0001, 1);
    for (int k = 0; k < 6; k++) begin
      acc(pcr_pkg::CMD_PGD, 1, 1, w[k], 1);
      cyc(3);
      ms = lin_ms(w[k]);
      chk({3'h0, good_delay_ms}, 16'(ms));
      if (ms <= 5) begin
        acc(pcr_pkg::CMD_MISC, 1, 1, {13'h0, k[0], 2'b00}, 1);
        if (ms >= 2) begin
          // A dip part-way through must restart the count
          set_vout(1'b1);
          cyc(ms * MSC / 2);
          set_vout(1'b0);
          cyc(8);
        end
        set_vout(1'b1);
        cyc(ms * MSC);
        chk({13'h0, power_good, loop_high_bw, pin_level}, 16'h0);
        wait_good(1'b1, 20);
        cyc(1);
        chk({13'h0, loop_high_bw, pin_level, output_good_pin_oe},
          {13'h0, 2'b11, k[0]});
        set_vout(1'b0);
        wait_good(1'b0, 10);
      end
    end
    finish_test();
  end
endmodule : pcr_regs_bench
`default_nettype wire
